// ===== include/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   // Sample and port widths
   localparam int SAMPLE_W = 12;
   localparam int CTRL_W = 10;
   // Register select carried in data bits 11:10 of a write
   localparam logic [1:0] SEL_CTRL0 = 2'h0;
   localparam logic [1:0] SEL_CTRL1 = 2'h1;
   // Control register 0 fields
   localparam int C0_SINGLE_BIT = 1;
   localparam int C0_SCAN_BIT = 7;
   localparam int C0_TEST_LSB = 8;
   localparam logic [CTRL_W-1:0] CTRL0_RESET = 10'h020;
   // Control register 1 fields
   localparam int C1_RESET_BIT = 0;
   localparam int C1_FIFO_BIT = 1;
   localparam int C1_STORED_LSB = 2;
   localparam logic [7:0] CTRL1_STORED_RESET = 8'h0c;
   // Test source codes
   localparam logic [1:0] TEST_NORMAL = 2'h0;
   localparam logic [1:0] TEST_REF_UPPER = 2'h1;
   localparam logic [1:0] TEST_REF_MID = 2'h2;
   localparam logic [1:0] TEST_REF_LOWER = 2'h3;
   // Timing
   localparam logic [2:0] STARTUP_TICKS = 3'h5;
   localparam logic [SAMPLE_W-1:0] MID_SCALE = 12'h800;
   // Fill thresholds, one and two channels, indexed by the 2-bit code
   localparam logic [4:0] THRESH_ONE [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
   localparam logic [4:0] THRESH_TWO [4] = '{5'h02, 5'h04, 5'h08, 5'h0c};

   // Stored part of control register 1, bits 9 down to 2
   typedef struct packed {
      logic config_readback_enable;
      logic offset_cal;
      logic output_format_select;
      logic rw_mode;
      logic av_polarity;
      logic av_pulse;
      logic [1:0] fill_threshold;
   } ctrl1_type;

   // Synchronised strobe pins
   typedef struct packed {
      logic conv_clk;
      logic cs0_n;
      logic cs1;
      logic rd_n;
      logic wr_n;
   } pins_type;
endpackage

// ===== sim/adc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_bench;
   import adc_ctrl_pkg::*;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, cs0_n_i = 1'b1, cs1_i = 1'b0;
   logic rd_n_i = 1'b1, wr_n_i = 1'b1, run = 1'b0, rw = 1'b0, ce = 1'b1;
   logic conv_clk, oe_n, ready, ovf, tick;
   logic [11:0] data_i = '0, data_o, result;
   logic [1:0] test_sel;
   int bad_count = 0, n_compared = 0, n;
   always #10 sys_clk_i = !sys_clk_i;
   conv_source u_conv_source (.sys_clk_i, .run_i(run), .conv_clk_o(conv_clk), .result_o(result));
   adc_ctrl u_adc_ctrl (.sys_clk_i, .rst_n_i, .ce_i(ce), .cs0_n_i, .cs1_i, .rd_n_i, .wr_n_i,
      .conv_clk_i(conv_clk), .data_i, .data_o, .data_oe_n_o(oe_n), .samples_ready_out_o(ready),
      .fifo_overrun_flag_o(ovf), .adc_result_i(result), .test_select_o(test_sel),
      .conv_tick_o(tick));
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [9:0] v);
      {cs0_n_i, cs1_i, wr_n_i, data_i} <= {3'b010, sel, v};
      cyc(6);
      // Data holds until the synchronised strobe has dropped
      {cs0_n_i, cs1_i, wr_n_i} <= 3'b101;
      cyc(6);
      data_i <= {~sel, ~v};
      cyc(2);
   endtask
   // In direction mode the read strobe stays idle, so only the direction pin reads
   task automatic rd(input logic [11:0] exp);
      {cs0_n_i, cs1_i, rd_n_i} <= {2'b01, rw};
      cyc(6);
      chk(oe_n, 12'h0);
      chk(data_o, exp);
      {cs0_n_i, cs1_i, rd_n_i} <= 3'b101;
      cyc(8);
   endtask
   task automatic ticks(input int k);
      run <= 1'b1;
      cyc(16 * k);
      run <= 1'b0;
      cyc(24);
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(20000);
      bad_count++;
      wrap_up();
   end
   initial
   begin
      cyc(12);
      rst_n_i <= 1'b1;
      cyc(4);
      wr(SEL_CTRL1, 10'h230);
      rd(12'h020);
      rd(12'h230);
      for (int c = 0; c < 4; c++)
      begin
         wr(SEL_CTRL0, {c[1:0], 8'h20});
         chk(test_sel, c[11:0]);
      end
      ce <= 1'b0;
      wr(SEL_CTRL0, 10'h020);
      ce <= 1'b1;
      chk(test_sel, 12'h3);
      $display("register test done");
      ticks(30);
      chk(ovf, 12'h1);
      wr(SEL_CTRL1, 10'h230);
      rd(12'h320);
      rd(12'h232);
      chk(ovf, 12'h0);
      wr(SEL_CTRL1, 10'h02c);
      chk(ready, 12'h1);
      wr(SEL_CTRL1, 10'h00c);
      chk(ready, 12'h0);
      wr(SEL_CTRL1, 10'h02e);
      chk(ready, 12'h0);
      rd(12'h000);
      $display("overflow test done");
      wr(SEL_CTRL1, 10'h0b2);
      ticks(2);
      rd(12'h9a5);
      wr(SEL_CTRL1, 10'h032);
      ticks(2);
      rd(12'h1a5);
      wr(SEL_CTRL1, 10'h1b2);
      ticks(2);
      rd(12'h800);
      $display("format test done");
      wr(SEL_CTRL0, 10'h322);
      n = 0;
      repeat (60)
      begin
         @(posedge sys_clk_i);
         #1;
         if (tick)
            n++;
      end
      @(posedge sys_clk_i);
      chk(n[11:0], 12'h00a);
      wr(SEL_CTRL1, 10'h001);
      chk(test_sel, 12'h0);
      run <= 1'b1;
      n = 0;
      while (!ready && n < 9)
      begin
         @(posedge sys_clk_i);
         #1;
         if (tick)
            n++;
      end
      chk(n[11:0], 12'h5);
      @(posedge sys_clk_i);
      run <= 1'b0;
      cyc(24);
      rd(12'h1a5);
      $display("soft reset test done");
      wr(SEL_CTRL0, 10'h0a0);
      wr(SEL_CTRL1, 10'h022);
      ticks(1);
      chk(ready, 12'h0);
      ticks(1);
      chk(ready, 12'h1);
      wr(SEL_CTRL1, 10'h02e);
      ticks(12);
      chk(ready, 12'h1);
      wr(SEL_CTRL0, 10'h020);
      chk(ready, 12'h0);
      $display("threshold test done");
      wr(SEL_CTRL1, 10'h270);
      rw = 1'b1;
      rd(12'h020);
      rd(12'h270);
      wr(SEL_CTRL1, 10'h272);
      rd(12'h020);
      rd(12'h270);
      rd(12'h000);
      $display("direction mode test done");
      wrap_up();
   end
endmodule // adc_ctrl_bench
`default_nettype wire

// ===== sim/adc_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties
   import adc_ctrl_pkg::*;
(
   // Watched ports
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic cs0_n_i,
   input wire logic cs1_i,
   input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] data_o,
   input wire logic data_oe_n_o,
   input wire logic samples_ready_out_o,
   input wire logic fifo_overrun_flag_o,
   input wire logic [1:0] test_select_o,
   input wire logic conv_tick_o
);
   // Ages cover the pin synchronisers, so bounds are loose on purpose
   logic [3:0] cs_age = 4'hf;
   logic [3:0] tick_age = 4'hf;
   always_ff @(posedge sys_clk_i)
   begin
      cs_age <= (!cs0_n_i && cs1_i) ? 4'h0 : cs_age + {3'h0, cs_age != 4'hf};
      tick_age <= conv_tick_o ? 4'h0 : tick_age + {3'h0, tick_age != 4'hf};
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   reset_state_a: assert property ($rose(rst_n_i) |-> data_oe_n_o && !fifo_overrun_flag_o
      && test_select_o == 2'h0 && data_o == '0) else $error("outputs not at reset state");
   ready_reset_a: assert property ($rose(rst_n_i) |=> !samples_ready_out_o)
      else $error("samples ready active after reset");
   tick_pulse_a: assert property (conv_tick_o |=> !conv_tick_o)
      else $error("conversion tick longer than one cycle");
   drive_select_a: assert property (!data_oe_n_o |-> cs_age < 4'h8)
      else $error("data driven without chip select");
   data_hold_a: assert property (!$stable(data_o) |-> !data_oe_n_o)
      else $error("read data changed outside a read");
   test_hold_a: assert property (!$stable(test_select_o) |-> cs_age < 4'hc)
      else $error("test select changed without a write");
   ovf_set_a: assert property ($rose(fifo_overrun_flag_o) |-> tick_age < 4'h4)
      else $error("overflow set without a conversion");
   ovf_clear_a: assert property ($fell(fifo_overrun_flag_o) |-> cs_age < 4'hc)
      else $error("overflow cleared without an access");
endmodule // adc_ctrl_properties
bind adc_ctrl adc_ctrl_properties u_adc_ctrl_properties (.sys_clk_i, .rst_n_i, .cs0_n_i,
   .cs1_i, .data_o, .data_oe_n_o, .samples_ready_out_o, .fifo_overrun_flag_o, .test_select_o,
   .conv_tick_o);
`default_nettype wire

// ===== sim/conv_source.sv
`timescale 1ns/1ps
`default_nettype none
module conv_source
   import adc_ctrl_pkg::*;
#(
   parameter logic [11:0] RESULT = 12'h9a5
) (
   input wire logic sys_clk_i,
   input wire logic run_i,
   output logic conv_clk_o,
   output logic [adc_ctrl_pkg::SAMPLE_W-1:0] result_o
);
   logic [2:0] phase_q = 3'h0;
   assign result_o = RESULT;
   initial conv_clk_o = 1'b0;
   always @(posedge sys_clk_i)
   begin
      phase_q <= phase_q + 3'h1;
      // Held low between bursts so no stray tick reaches the device
      if (!run_i)
         conv_clk_o <= 1'b0;
      else if (phase_q == 3'h7)
         conv_clk_o <= !conv_clk_o;
   end
endmodule // conv_source
`default_nettype wire

// ===== verilog/adc_ctrl.sv
// Overview of operation
// - Control register 0 bits 9:8 select normal input, upper, mid or lower reference.
// - Writing one to control register 1 bit 0 resets both control registers.
// - Soft reset also clears FIFO pointers and stored offset correction.
// - After reset the first sample enters the FIFO on the fifth conversion tick.
// - Control register 1 bit 1 reads one after a FIFO overflow, else zero.
// - Overflow flag clears once control register 1 has been read.
// - Writing one to control register 1 bit 1 clears the FIFO.
// - Bits 3:2 set fill threshold; reaching it asserts the samples-ready output.
// - Threshold codes mean 1,4,8,14 samples or 2,4,8,12 with two channels.
// - Bit 4 chooses level (0) or pulse (1) signalling; resets to one.
// - Bit 5 chooses active high (1) or active low (0); resets to one.
// - Bit 6 turns write strobe into read/write direction and ignores read strobe.
// - Bit 7 selects two's complement (0) or straight binary (1) output.
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic clear_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   // Fill level
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign count_o = cnt_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   always_comb
   begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (clear_i)
      begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end
      else
      begin
         if (push)
            wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         if (pop)
            rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (ce_i)
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         if (push && !clear_i)
            mem_q[wr_q] <= in_data_i;
      end
   end
endmodule // sample_fifo

module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int OSC_DIV = 6
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Host strobe pins
   input wire logic cs0_n_i,
   input wire logic cs1_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic conv_clk_i,
   // Host data pins
   input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] data_i,
   output logic [adc_ctrl_pkg::SAMPLE_W-1:0] data_o,
   output logic data_oe_n_o,
   output logic samples_ready_out_o,
   output logic fifo_overrun_flag_o,
   // Converter core
   input wire logic [adc_ctrl_pkg::SAMPLE_W-1:0] adc_result_i,
   output logic [1:0] test_select_o,
   output logic conv_tick_o
);
   import adc_ctrl_pkg::*;

   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   pins_type pin_raw, s1_q, s2_q, s3_q, stab_q, stab_d;
   logic [CTRL_W-1:0] ctrl0_q, ctrl0_d;
   ctrl1_type ctrl1_q, ctrl1_d;
   logic ovf_q, ovf_d, av_q, av_d, hit_q, hit_d, oe_n_q, oe_n_d;
   logic [SAMPLE_W-1:0] offset_q, offset_d, out_q, out_d, wdata_q, wdata_d;
   logic [2:0] warm_q, warm_d;
   logic [1:0] rb_q, rb_d;
   logic [7:0] osc_q, osc_d;
   logic cs_on, rd_on, wr_on, rd_on_q, wr_on_q, rd_start, wr_end, tick, soft_rst, fifo_clr;
   logic [SAMPLE_W-1:0] corrected, formatted, ctrl1_view;
   logic push, f_ready, f_valid, pop, hit;
   logic [SAMPLE_W-1:0] f_data;
   logic [CW-1:0] f_count;
   logic [4:0] thresh;

   // Pins pass three flops; a change counts once the second and third agree
   assign pin_raw = '{conv_clk: conv_clk_i, cs0_n: cs0_n_i, cs1: cs1_i,
                      rd_n: rd_n_i, wr_n: wr_n_i};
   always_comb
   begin
      stab_d = stab_q;
      for (int i = 0; i < $bits(pins_type); i++)
         if (s2_q[i] == s3_q[i])
            stab_d[i] = s3_q[i];
   end

   // Internal access strobes
   assign cs_on = !stab_q.cs0_n && stab_q.cs1;
   always_comb
   begin
      if (ctrl1_q.rw_mode)
      begin
         rd_on = cs_on && stab_q.wr_n;
         wr_on = cs_on && !stab_q.wr_n;
      end
      else
      begin
         rd_on = cs_on && !stab_q.rd_n && stab_q.wr_n;
         wr_on = cs_on && !stab_q.wr_n && stab_q.rd_n;
      end
   end
   assign rd_start = rd_on && !rd_on_q;
   // Writes take effect at the end of the strobe, when the data has settled
   assign wr_end = !wr_on && wr_on_q;
   assign soft_rst = wr_end && (wdata_q[11:10] == SEL_CTRL1) && wdata_q[C1_RESET_BIT];
   assign fifo_clr = soft_rst || (wr_end && (wdata_q[11:10] == SEL_CTRL1)
                     && wdata_q[C1_FIFO_BIT]);

   // Conversion tick: internal oscillator in single mode, else external clock edge
   assign tick = ctrl0_q[C0_SINGLE_BIT] ? (osc_q == 8'(OSC_DIV - 1))
                 : (stab_d.conv_clk && !stab_q.conv_clk);

   // Offset correction and output format
   assign corrected = adc_result_i - offset_q;
   assign formatted = ctrl1_q.output_format_select ? corrected
                      : {~corrected[SAMPLE_W-1], corrected[SAMPLE_W-2:0]};
   assign push = tick && (warm_q == STARTUP_TICKS - 3'h1 || warm_q == STARTUP_TICKS)
                 && !ctrl1_q.offset_cal && !fifo_clr;
   assign ctrl1_view = {2'h0, ctrl1_q, ovf_q, 1'b0};

   // Threshold depends on one or two active channels
   assign thresh = ctrl0_q[C0_SCAN_BIT] ? THRESH_TWO[ctrl1_q.fill_threshold]
                   : THRESH_ONE[ctrl1_q.fill_threshold];
   assign hit = (f_count >= CW'(thresh));
   assign pop = rd_start && (rb_q == 2'h0);

   always_comb
   begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      ovf_d = ovf_q;
      offset_d = offset_q;
      warm_d = warm_q;
      rb_d = rb_q;
      out_d = out_q;
      oe_n_d = !rd_on;
      wdata_d = wr_on ? data_i : wdata_q;
      osc_d = (!ctrl0_q[C0_SINGLE_BIT] || tick) ? 8'h0 : osc_q + 8'h1;
      hit_d = hit;
      if (tick && warm_q != STARTUP_TICKS)
         warm_d = warm_q + 3'h1;
      if (tick && ctrl1_q.offset_cal && warm_q == STARTUP_TICKS)
      begin
         // Inputs are grounded for this conversion, so midscale is the ideal result
         offset_d = adc_result_i - MID_SCALE;
         ctrl1_d.offset_cal = 1'b0;
      end
      if (rd_start)
      begin
         if (rb_q == 2'h1)
            out_d = {2'h0, ctrl0_q};
         else if (rb_q == 2'h2)
            out_d = ctrl1_view;
         else
            out_d = f_valid ? f_data : '0;
         if (rb_q == 2'h2)
         begin
            ovf_d = 1'b0;
            rb_d = 2'h0;
         end
         else if (rb_q == 2'h1)
            rb_d = 2'h2;
      end
      if (wr_end && wdata_q[11:10] == SEL_CTRL0)
         ctrl0_d = wdata_q[CTRL_W-1:0];
      if (wr_end && wdata_q[11:10] == SEL_CTRL1)
      begin
         // Command bits 1:0 are not kept
         ctrl1_d = ctrl1_type'(wdata_q[CTRL_W-1:C1_STORED_LSB]);
         rb_d = wdata_q[CTRL_W-1] ? 2'h1 : 2'h0;
      end
      // A sample lost to a full FIFO sets the flag even in a clearing read
      if (tick && !f_ready && warm_q == STARTUP_TICKS && !ctrl1_q.offset_cal && !fifo_clr)
         ovf_d = 1'b1;
      if (soft_rst)
      begin
         ctrl0_d = CTRL0_RESET;
         ctrl1_d = ctrl1_type'(CTRL1_STORED_RESET);
         offset_d = '0;
         warm_d = 3'h0;
         rb_d = 2'h0;
         ovf_d = 1'b0;
      end
      // Pulse style lasts one cycle on reaching the threshold, level style follows it
      av_d = ctrl1_q.av_pulse ? (hit && !hit_q) : hit;
      av_d = ctrl1_q.av_polarity ? av_d : !av_d;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         stab_q <= '1;
         rd_on_q <= 1'b0;
         wr_on_q <= 1'b0;
         ctrl0_q <= CTRL0_RESET;
         ctrl1_q <= ctrl1_type'(CTRL1_STORED_RESET);
         ovf_q <= 1'b0;
         offset_q <= '0;
         warm_q <= 3'h0;
         rb_q <= 2'h0;
         out_q <= '0;
         oe_n_q <= 1'b1;
         wdata_q <= '0;
         osc_q <= 8'h0;
         hit_q <= 1'b0;
         av_q <= 1'b0;
      end
      else if (ce_i)
      begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stab_q <= stab_d;
         rd_on_q <= rd_on;
         wr_on_q <= wr_on;
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         ovf_q <= ovf_d;
         offset_q <= offset_d;
         warm_q <= warm_d;
         rb_q <= rb_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         wdata_q <= wdata_d;
         osc_q <= osc_d;
         hit_q <= hit_d;
         av_q <= av_d;
      end
   end

   sample_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_sample_fifo (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .clear_i(fifo_clr),
      .in_valid_i(push),
      .in_data_i(formatted),
      .in_ready_o(f_ready),
      .out_valid_o(f_valid),
      .out_data_o(f_data),
      .out_ready_i(pop),
      .count_o(f_count)
   );

   assign test_select_o = ctrl0_q[C0_TEST_LSB +: 2];
   assign data_o = out_q;
   assign data_oe_n_o = oe_n_q;
   assign samples_ready_out_o = av_q;
   assign fifo_overrun_flag_o = ovf_q;
   assign conv_tick_o = tick;
endmodule // adc_ctrl

`default_nettype wire
